// ### pps_pkg.sv
package pps_pkg;

  // Register byte addresses on the Avalon slave
  localparam logic [4:0] ADDR_CTRL      = 5'h00;
  localparam logic [4:0] ADDR_TARGET    = 5'h04;
  localparam logic [4:0] ADDR_WRAP_MODE = 5'h08;
  localparam logic [4:0] ADDR_WRAP_EN   = 5'h0C;
  localparam logic [4:0] ADDR_POS_WIN   = 5'h10;
  localparam logic [4:0] ADDR_STATUS    = 5'h14;
  localparam logic [4:0] ADDR_DEST      = 5'h18;
  localparam logic [4:0] ADDR_CMD_POS   = 5'h1C;

  // Control word bit positions
  localparam int CB_STROBE    = 4;
  localparam int CB_IMMEDIATE = 5;
  localparam int CB_ABS_REL   = 6;
  localparam int CB_HALT      = 8;
  localparam int CB_REL_ORIG  = 12;
  localparam int CB_PUSH      = 13;
  localparam int CB_WRAP      = 14;

  // Status word bit positions
  localparam int SB_BUSY      = 0;
  localparam int SB_PENDING   = 1;
  localparam int SB_WRAP_ERR  = 2;
  localparam int SB_REACHED   = 10;
  localparam int SB_ACK       = 12;
  localparam int SB_TLC       = 15;

  // Values after reset
  localparam logic [15:0] CTRL_RST    = 16'h0000;
  localparam logic [31:0] TARGET_RST  = 32'h0000_0000;
  localparam logic [1:0]  WMODE_RST   = 2'h0;
  localparam logic [31:0] POS_WIN_RST = 32'h0000_0010;

  // Move kinds: top bit marks a wrap move, low bits the wrap mode
  typedef enum logic [2:0] {
    PPS_ABS       = 3'h0,
    PPS_INC_CMD   = 3'h1,
    PPS_INC_FB    = 3'h2,
    PPS_WRAP_ABS  = 3'h4,
    PPS_WRAP_PROX = 3'h5,
    PPS_WRAP_FWD  = 3'h6,
    PPS_WRAP_REV  = 3'h7
  } pps_kind_t;

  typedef enum logic [1:0] {
    PPS_IDLE   = 2'h0,
    PPS_RUN    = 2'h1,
    PPS_SETTLE = 2'h2
  } pps_state_t;

endpackage

// ### pps_dest.sv
`timescale 1ns/100ps
// Forms the move destination from the sampled target and move kind
module pps_dest #(
  parameter int POS_W = 32
) (
  input  wire pps_pkg::pps_kind_t  kind,    // Move kind
  input  wire logic [POS_W-1:0]    target,  // Target or travel
  input  wire logic [POS_W-1:0]    cmd_pos, // Present command position
  input  wire logic [POS_W-1:0]    fb_pos,  // Present feedback position
  output logic      [POS_W-1:0]    dest     // Destination coordinate
);

  wire [POS_W-1:0] sum_cmd;
  wire [POS_W-1:0] sum_fb;

  // Two's complement wrap of the sum is intended
  assign sum_cmd = target + cmd_pos;
  assign sum_fb  = target + fb_pos;

  // Wrap moves pass the in-range coordinate to the motion core unchanged
  assign dest = (kind == pps_pkg::PPS_INC_CMD) ? sum_cmd :
                (kind == pps_pkg::PPS_INC_FB)  ? sum_fb  :
                target;

endmodule // pps_dest

// ### pps_seq.sv
`timescale 1ns/100ps
// Contract
// - Target loaded first; set-point strobe starts a positioning move.
// - Immediate select 1: new strobe during a move replaces it at once.
// - Immediate select 0: new strobe is stored, started after current move.
// - Push bit at strobe gives rectangular self-start at profile velocity.
// - Pressing a load during push-motion sets the torque limit flag.
// - Halt or stop input while pressing stops and cancels push state.
// - Push move reaching target without contact leaves flag at 0.
// - Wrap select at strobe forces absolute wrap move, ignores abs/rel.
// - No wrap: abs/rel and relative origin choose move; push adds push.
// - Wrap mode 0..3 picks absolute, proximity, forward or reverse.
// - Absolute move: target is a coordinate measured from home.
// - Command incremental: destination is command position plus travel.
// - Feedback incremental: destination is actual position plus travel.
// - Acknowledge set on accepted start, cleared when strobe returns 0.
// - Target reached after proper completion within the position window; code also sets it when a move ends under halt, with no window check.
module pps_seq #(
  parameter int          POS_W   = 32,
  parameter logic [31:0] WIN_RST = pps_pkg::POS_WIN_RST
) (
  input  wire  logic              clock,            // 20 MHz clock
  input  wire  logic              rst,              // Sync reset, high
  input  wire  logic [4:0]        avs_address,      // Byte address
  input  wire  logic              avs_read,         // Read request
  input  wire  logic              avs_write,        // Write request
  input  wire  logic [31:0]       avs_writedata,    // Write data
  output logic       [31:0]       avs_readdata,     // Read data
  output logic                    avs_waitrequest,  // Stall
  input  wire  logic [POS_W-1:0]  cmd_pos,          // Command position
  input  wire  logic [POS_W-1:0]  fb_pos,           // Feedback position
  input  wire  logic              move_done,        // Core finished, pulse
  input  wire  logic              load_pressed,     // Core torque at limit
  input  wire  logic              stop_in,          // Stop pin, async
  output logic                    move_start,       // Start pulse
  output pps_pkg::pps_kind_t      move_kind,        // Kind of started move
  output logic       [POS_W-1:0]  move_dest,        // Destination
  output logic                    move_push,        // Push, rectangular
  output logic                    move_halt,        // Decelerate to stop
  output logic                    setpoint_ack,     // Acknowledge bit
  output logic                    target_reached,   // Target reached bit
  output logic                    torque_limit_reached_flag // Load pressed
);

  logic [15:0]        ctrl_r;
  logic [POS_W-1:0]   target_r;
  logic [1:0]         wrap_mode_r;
  logic               wrap_en_r;
  logic [31:0]        win_r;
  logic               ack_r;
  logic [31:0]        rdata_r;
  logic               strobe_prev_r;
  logic               stop_s1_r;
  logic               stop_s2_r;
  pps_pkg::pps_state_t state_r, state_nxt;
  logic               pend_r, pend_nxt;
  pps_pkg::pps_kind_t pend_kind_r, pend_kind_nxt;
  logic [POS_W-1:0]   pend_tgt_r, pend_tgt_nxt;
  logic               pend_push_r, pend_push_nxt;
  logic               push_act_r, push_act_nxt;
  logic               tlc_r, tlc_nxt;
  logic               reached_r, reached_nxt;
  logic               sp_ack_r, sp_ack_nxt;
  logic               werr_r, werr_nxt;
  logic               start_r, start_nxt;
  pps_pkg::pps_kind_t kind_r;
  logic [POS_W-1:0]   dest_r;
  logic               push_r;

  function automatic pps_pkg::pps_kind_t kind_of(input logic [15:0] cw,
                                                 input logic [1:0]  wm);
    if (cw[pps_pkg::CB_WRAP])
      kind_of = pps_pkg::pps_kind_t'({1'b1, wm});
    else if (!cw[pps_pkg::CB_ABS_REL])
      kind_of = pps_pkg::PPS_ABS;
    else if (cw[pps_pkg::CB_REL_ORIG])
      kind_of = pps_pkg::PPS_INC_FB;
    else
      kind_of = pps_pkg::PPS_INC_CMD;
  endfunction

  function automatic logic in_window(input logic [POS_W-1:0] a,
                                     input logic [POS_W-1:0] b,
                                     input logic [31:0]      w);
    logic [POS_W-1:0] d;
    d = $signed(a) >= $signed(b) ? a - b : b - a;
    in_window = d <= POS_W'(w);
  endfunction

  // Bus slave: one wait cycle on every access, read data registered
  wire bus_req   = avs_read | avs_write;
  wire bus_first = bus_req & ~ack_r;
  wire wr_fire   = avs_write & ack_r;
  assign avs_waitrequest = bus_first;
  assign avs_readdata    = rdata_r;

  wire wr_ctrl   = wr_fire & (avs_address == pps_pkg::ADDR_CTRL);
  wire wr_target = wr_fire & (avs_address == pps_pkg::ADDR_TARGET);
  wire wr_wmode  = wr_fire & (avs_address == pps_pkg::ADDR_WRAP_MODE);
  wire wr_wen    = wr_fire & (avs_address == pps_pkg::ADDR_WRAP_EN);
  wire wr_win    = wr_fire & (avs_address == pps_pkg::ADDR_POS_WIN);

  wire [31:0] status_w = 32'(
      {tlc_r, 2'h0, sp_ack_r, 1'b0, reached_r, 7'h00, werr_r,
       pend_r, state_r != pps_pkg::PPS_IDLE});
  wire [31:0] rd_mux =
      (avs_address == pps_pkg::ADDR_CTRL)      ? {16'h0000, ctrl_r}     :
      (avs_address == pps_pkg::ADDR_TARGET)    ? 32'(target_r)          :
      (avs_address == pps_pkg::ADDR_WRAP_MODE) ? {30'h0, wrap_mode_r}   :
      (avs_address == pps_pkg::ADDR_WRAP_EN)   ? {31'h0, wrap_en_r}     :
      (avs_address == pps_pkg::ADDR_POS_WIN)   ? win_r                  :
      (avs_address == pps_pkg::ADDR_STATUS)    ? status_w               :
      (avs_address == pps_pkg::ADDR_DEST)      ? 32'(dest_r)            :
      (avs_address == pps_pkg::ADDR_CMD_POS)   ? 32'(cmd_pos)           :
      32'h0000_0000;

  // Sequencing decisions
  wire strobe    = ctrl_r[pps_pkg::CB_STROBE];
  wire rise      = strobe & ~strobe_prev_r;
  wire halt_any  = ctrl_r[pps_pkg::CB_HALT] | stop_s2_r;
  wire immediate = ctrl_r[pps_pkg::CB_IMMEDIATE];
  wire running   = state_r == pps_pkg::PPS_RUN;
  pps_pkg::pps_kind_t live_kind;
  assign live_kind = kind_of(ctrl_r, wrap_mode_r);
  // Wrap moves need the wrap function enabled; otherwise refused
  wire wrap_bad  = live_kind[2] & ~wrap_en_r;
  wire accept    = rise & ~wrap_bad & ~halt_any;
  wire pressing  = running & push_act_r & load_pressed & ~halt_any;
  // Queued start uses the stored command; only when no live one wins
  wire use_pend  = running & move_done & pend_r & ~halt_any & ~accept;
  wire start_now = (accept & (~running | immediate | move_done)) | use_pend;

  pps_pkg::pps_kind_t sel_kind;
  assign sel_kind = use_pend ? pend_kind_r : live_kind;
  wire [POS_W-1:0] sel_tgt  = use_pend ? pend_tgt_r : target_r;
  wire             sel_push = use_pend ? pend_push_r
                                       : ctrl_r[pps_pkg::CB_PUSH];
  wire [POS_W-1:0] sel_dest;

  pps_dest #(.POS_W(POS_W)) u_dest (
    .kind    (sel_kind),
    .target  (sel_tgt),
    .cmd_pos (cmd_pos),
    .fb_pos  (fb_pos),
    .dest    (sel_dest)
  );

  always_comb begin
    state_nxt     = state_r;
    pend_nxt      = pend_r;
    pend_kind_nxt = pend_kind_r;
    pend_tgt_nxt  = pend_tgt_r;
    pend_push_nxt = pend_push_r;
    push_act_nxt  = push_act_r;
    tlc_nxt       = tlc_r | pressing;
    reached_nxt   = reached_r;
    werr_nxt      = werr_r | (rise & wrap_bad);
    start_nxt     = start_now;
    // Set on accept wins over the clear by a low strobe
    sp_ack_nxt    = accept | (sp_ack_r & strobe);
    if (start_now) begin
      state_nxt    = pps_pkg::PPS_RUN;
      push_act_nxt = sel_push;
      tlc_nxt      = 1'b0;
      reached_nxt  = 1'b0;
      werr_nxt     = rise & wrap_bad;
      if (use_pend)
        pend_nxt = 1'b0;
    end else if (running & halt_any & push_act_r & tlc_r) begin
      state_nxt    = pps_pkg::PPS_IDLE;
      push_act_nxt = 1'b0;
      tlc_nxt      = 1'b0;
      pend_nxt     = 1'b0;
    end else if (running & move_done) begin
      pend_nxt     = 1'b0;
      push_act_nxt = 1'b0;
      if (halt_any) begin
        state_nxt   = pps_pkg::PPS_IDLE;
        reached_nxt = 1'b1;
      end else begin
        state_nxt   = pps_pkg::PPS_SETTLE;
      end
    end else if (accept & running) begin
      pend_nxt      = 1'b1;
      pend_kind_nxt = live_kind;
      pend_tgt_nxt  = target_r;
      pend_push_nxt = ctrl_r[pps_pkg::CB_PUSH];
    end else if (state_r == pps_pkg::PPS_SETTLE) begin
      if (halt_any)
        state_nxt = pps_pkg::PPS_IDLE;
      else if (in_window(fb_pos, cmd_pos, win_r)) begin
        state_nxt   = pps_pkg::PPS_IDLE;
        reached_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ack_r   <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      ack_r   <= bus_first;
      rdata_r <= bus_first ? rd_mux : rdata_r;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_r      <= pps_pkg::CTRL_RST;
      target_r    <= POS_W'(pps_pkg::TARGET_RST);
      wrap_mode_r <= pps_pkg::WMODE_RST;
      wrap_en_r   <= 1'b0;
      win_r       <= WIN_RST;
    end else begin
      if (wr_ctrl)   ctrl_r      <= avs_writedata[15:0];
      if (wr_target) target_r    <= avs_writedata[POS_W-1:0];
      if (wr_wmode)  wrap_mode_r <= avs_writedata[1:0];
      if (wr_wen)    wrap_en_r   <= avs_writedata[0];
      if (wr_win)    win_r       <= avs_writedata;
    end
  end

  // Stop pin crosses in through two flops
  always_ff @(posedge clock) begin
    if (rst) begin
      stop_s1_r     <= 1'b0;
      stop_s2_r     <= 1'b0;
      strobe_prev_r <= 1'b0;
    end else begin
      stop_s1_r     <= stop_in;
      stop_s2_r     <= stop_s1_r;
      strobe_prev_r <= strobe;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_r     <= pps_pkg::PPS_IDLE;
      pend_r      <= 1'b0;
      pend_kind_r <= pps_pkg::PPS_ABS;
      pend_tgt_r  <= '0;
      pend_push_r <= 1'b0;
      push_act_r  <= 1'b0;
      tlc_r       <= 1'b0;
      reached_r   <= 1'b0;
      sp_ack_r    <= 1'b0;
      werr_r      <= 1'b0;
      start_r     <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      pend_r      <= pend_nxt;
      pend_kind_r <= pend_kind_nxt;
      pend_tgt_r  <= pend_tgt_nxt;
      pend_push_r <= pend_push_nxt;
      push_act_r  <= push_act_nxt;
      tlc_r       <= tlc_nxt;
      reached_r   <= reached_nxt;
      sp_ack_r    <= sp_ack_nxt;
      werr_r      <= werr_nxt;
      start_r     <= start_nxt;
    end
  end

  // Command snapshot handed to the motion core
  always_ff @(posedge clock) begin
    if (rst) begin
      kind_r <= pps_pkg::PPS_ABS;
      dest_r <= '0;
      push_r <= 1'b0;
    end else if (start_now) begin
      kind_r <= sel_kind;
      dest_r <= sel_dest;
      push_r <= sel_push;
    end
  end

  assign move_start                = start_r;
  assign move_kind                 = kind_r;
  assign move_dest                 = dest_r;
  assign move_push                 = push_r & push_act_r;
  assign move_halt                 = halt_any;
  assign setpoint_ack              = sp_ack_r;
  assign target_reached            = reached_r;
  assign torque_limit_reached_flag = tlc_r;

  wire [POS_W-1:0] chk_sum_cmd = sel_tgt + cmd_pos;

  sequence s_press;
    running && push_act_r && load_pressed && !halt_any && !start_now;
  endsequence

  sequence s_queue;
    accept && running && !immediate && !move_done;
  endsequence

  AST_START: assert property (@(posedge clock) disable iff (rst)
    accept && !running |=> move_start && state_r == pps_pkg::PPS_RUN)
    else $error("accepted strobe did not start a move");
  AST_REPLACE: assert property (@(posedge clock) disable iff (rst)
    accept && running && immediate |=> move_start ##1 !move_start)
    else $error("immediate strobe did not replace the move");
  AST_QUEUE: assert property (@(posedge clock) disable iff (rst)
    s_queue |=> pend_r && !move_start)
    else $error("queued strobe not stored");
  AST_TLC: assert property (@(posedge clock) disable iff (rst)
    s_press |=> torque_limit_reached_flag)
    else $error("pressing did not raise the torque flag");
  AST_CANCEL: assert property (@(posedge clock) disable iff (rst)
    running && push_act_r && tlc_r && halt_any && !start_now
      |=> state_r == pps_pkg::PPS_IDLE && !push_act_r)
    else $error("halt while pressing did not cancel push");
  AST_NO_TLC: assert property (@(posedge clock) disable iff (rst)
    !load_pressed && !tlc_r |=> !torque_limit_reached_flag)
    else $error("torque flag set without contact");
  AST_WRAP: assert property (@(posedge clock) disable iff (rst)
    start_now && !use_pend && ctrl_r[pps_pkg::CB_WRAP]
      |=> move_kind[2] && move_dest == $past(target_r))
    else $error("wrap move not absolute");
  AST_INC_CMD: assert property (@(posedge clock) disable iff (rst)
    start_now && sel_kind == pps_pkg::PPS_INC_CMD
      |=> move_dest == $past(chk_sum_cmd))
    else $error("command incremental destination wrong");
  AST_ACK: assert property (@(posedge clock) disable iff (rst)
    !strobe && !accept |=> !setpoint_ack)
    else $error("acknowledge not cleared by low strobe");
  AST_HELD: assert property (@(posedge clock) disable iff (rst)
    strobe && strobe_prev_r && !running && !use_pend |=> !move_start)
    else $error("held strobe started a move");
  AST_REACHED: assert property (@(posedge clock) disable iff (rst)
    state_r == pps_pkg::PPS_SETTLE && !halt_any && !start_now
      && in_window(fb_pos, cmd_pos, win_r) |=> target_reached)
    else $error("target reached not set in window");
  AST_BUS: assert property (@(posedge clock) disable iff (rst)
    bus_req && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest held longer than one cycle");

endmodule // pps_seq

// ### pps_core_model.sv
`timescale 1ns/100ps
// Motion core stand-in: runs a fixed-length move, may press a load
module pps_core_model (
  input  wire logic        clock,        // Clock
  input  wire logic        rst,          // Sync reset
  input  wire logic        move_start,   // Start pulse
  input  wire logic [31:0] move_dest,    // Destination
  input  wire logic        move_halt,    // Halt level
  input  wire logic [7:0]  run_len,      // Cycles per move
  input  wire logic        press,        // Load in the way
  input  wire logic [31:0] fb_off,       // Feedback lag at rest
  output logic      [31:0] cmd_pos,      // Command position
  output logic      [31:0] fb_pos,       // Feedback position
  output logic             move_done,    // Completion pulse
  output logic             load_pressed, // Torque at limit
  output logic             busy          // Move in progress
);
  logic [7:0]  cnt_r;
  logic [31:0] dest_r;
  // A pressed load never lets the move finish on its own
  assign load_pressed = busy & press;
  always_ff @(posedge clock) begin
    move_done <= 1'b0;
    if (rst) begin
      busy <= 1'b0;
      cnt_r <= 8'h00;
      dest_r <= 32'h0;
      cmd_pos <= 32'h0;
      fb_pos <= 32'h0;
    end else if (move_start) begin
      busy <= 1'b1;
      cnt_r <= run_len;
      dest_r <= move_dest;
    end else if (busy && (move_halt || (!press && cnt_r == 8'h00))) begin
      busy <= 1'b0;
      move_done <= 1'b1;
      cmd_pos <= dest_r;
      fb_pos <= dest_r + fb_off;
    end else if (busy && cnt_r != 8'h00) begin
      cnt_r <= cnt_r - 8'h01;
    end
  end
endmodule // pps_core_model

// ### tb.sv
`timescale 1ns/100ps
module tb;
  logic clock, rst, avs_read, avs_write, avs_waitrequest, move_done;
  logic load_pressed, stop_in, move_start, move_push, move_halt;
  logic setpoint_ack, target_reached, torque_limit_reached_flag;
  logic press, core_busy;
  logic [4:0]  avs_address;
  logic [7:0]  run_len;
  logic [31:0] avs_writedata, avs_readdata, cmd_pos, fb_pos, move_dest;
  logic [31:0] fb_off, last_dest, rd;
  pps_pkg::pps_kind_t move_kind, last_kind;
  int failures, compares, start_cnt, base;
  // Short return travel in steps before a push against a load ends
  localparam logic [31:0] BACK_OFF = 32'hFFFF_FFF6;

  pps_seq u_dut (.clock(clock), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cmd_pos(cmd_pos), .fb_pos(fb_pos),
    .move_done(move_done), .load_pressed(load_pressed), .stop_in(stop_in),
    .move_start(move_start), .move_kind(move_kind), .move_dest(move_dest),
    .move_push(move_push), .move_halt(move_halt),
    .setpoint_ack(setpoint_ack), .target_reached(target_reached),
    .torque_limit_reached_flag(torque_limit_reached_flag));
  pps_core_model u_core (.clock(clock), .rst(rst), .move_start(move_start),
    .move_dest(move_dest), .move_halt(move_halt), .run_len(run_len),
    .press(press), .fb_off(fb_off), .cmd_pos(cmd_pos), .fb_pos(fb_pos),
    .move_done(move_done), .load_pressed(load_pressed), .busy(core_busy));

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  always @(posedge clock) if (move_start === 1'b1) begin
    start_cnt <= start_cnt + 1;
    last_kind <= move_kind;
    last_dest <= move_dest;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    if (failures == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Waitrequest and read data are taken as they stood at the edge
  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rd = avs_readdata;
    if (n >= 20) chk(32'h0, 32'h1);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic start_mv(input logic [31:0] c, input logic [31:0] t);
    base = start_cnt;
    bus(1'b1, pps_pkg::ADDR_TARGET, t);
    bus(1'b1, pps_pkg::ADDR_CTRL, c & 32'hFFEF);
    bus(1'b1, pps_pkg::ADDR_CTRL, c | 32'h0010);
  endtask
  task automatic wait_start(input int lim, input logic exp);
    int n;
    n = 0;
    while (start_cnt == base && n < lim) begin
      @(posedge clock);
      n++;
    end
    chk(32'(start_cnt != base), 32'(exp));
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (core_busy !== 1'b0 && n < 200) begin
      @(posedge clock);
      n++;
    end
    repeat (3) @(posedge clock);
  endtask

  task automatic t_regs();
    bus(1'b0, pps_pkg::ADDR_STATUS, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, pps_pkg::ADDR_POS_WIN, 32'h0);
    chk(rd, pps_pkg::POS_WIN_RST);
    bus(1'b1, pps_pkg::ADDR_STATUS, 32'hFFFF);
    bus(1'b0, pps_pkg::ADDR_STATUS, 32'h0);
    chk(rd, 32'h0);
  endtask
  task automatic t_abs_inc();
    start_mv(32'h0, 32'd1000);
    wait_start(10, 1'b1);
    chk(32'(last_kind), 32'(pps_pkg::PPS_ABS));
    chk(last_dest, 32'd1000);
    chk(32'(setpoint_ack), 32'h1);
    base = start_cnt;
    bus(1'b1, pps_pkg::ADDR_CTRL, 32'h0010);
    wait_start(6, 1'b0);
    wait_idle();
    chk(32'(target_reached), 32'h1);
    bus(1'b1, pps_pkg::ADDR_CTRL, 32'h0);
    repeat (2) @(posedge clock);
    chk(32'(setpoint_ack), 32'h0);
    start_mv(32'h0040, 32'd3000);
    wait_start(10, 1'b1);
    chk(32'(last_kind), 32'(pps_pkg::PPS_INC_CMD));
    chk(last_dest, 32'd4000);
    wait_idle();
    fb_off <= 32'hFFFF_FF9C;
    start_mv(32'h0, 32'd1000);
    wait_start(10, 1'b1);
    wait_idle();
    chk(32'(target_reached), 32'h0);
    bus(1'b1, pps_pkg::ADDR_POS_WIN, 32'd100);
    repeat (2) @(posedge clock);
    chk(32'(target_reached), 32'h1);
    fb_off <= 32'h0;
    start_mv(32'h1040, 32'd3000);
    wait_start(10, 1'b1);
    chk(32'(last_kind), 32'(pps_pkg::PPS_INC_FB));
    bus(1'b0, pps_pkg::ADDR_DEST, 32'h0);
    chk(rd, 32'd3900);
    wait_idle();
    bus(1'b0, pps_pkg::ADDR_CMD_POS, 32'h0);
    chk(rd, 32'd3900);
    chk(fb_pos, 32'd3900);
  endtask
  task automatic t_wrap();
    bus(1'b1, pps_pkg::ADDR_WRAP_EN, 32'h0);
    start_mv(32'h4040, 32'd800);
    wait_start(6, 1'b0);
    bus(1'b0, pps_pkg::ADDR_STATUS, 32'h0);
    chk(32'(rd[pps_pkg::SB_WRAP_ERR]), 32'h1);
    bus(1'b1, pps_pkg::ADDR_WRAP_EN, 32'h1);
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, pps_pkg::ADDR_WRAP_MODE, 32'(m));
      start_mv(32'h5040, 32'd1000 + 32'(m));
      wait_start(10, 1'b1);
      chk(32'(last_kind), 32'h4 + 32'(m));
      chk(last_dest, 32'd1000 + 32'(m));
      wait_idle();
    end
  endtask
  task automatic t_update();
    run_len <= 8'd40;
    start_mv(32'h0020, 32'd100);
    wait_start(10, 1'b1);
    start_mv(32'h0020, 32'd200);
    wait_start(6, 1'b1);
    chk(last_dest, 32'd200);
    wait_idle();
    start_mv(32'h0, 32'd300);
    wait_start(10, 1'b1);
    start_mv(32'h0, 32'd400);
    wait_start(6, 1'b0);
    bus(1'b0, pps_pkg::ADDR_STATUS, 32'h0);
    chk(32'(rd[pps_pkg::SB_PENDING]), 32'h1);
    wait_start(80, 1'b1);
    chk(last_dest, 32'd400);
    wait_idle();
    run_len <= 8'd4;
  endtask
  task automatic t_push();
    start_mv(32'h2000, 32'd500);
    wait_start(10, 1'b1);
    chk(32'(move_push), 32'h1);
    wait_idle();
    chk(32'(torque_limit_reached_flag), 32'h0);
    chk(32'(target_reached), 32'h1);
    press <= 1'b1;
    start_mv(32'h2020, 32'd600);
    wait_start(10, 1'b1);
    repeat (3) @(posedge clock);
    chk(32'(torque_limit_reached_flag), 32'h1);
    bus(1'b1, pps_pkg::ADDR_CTRL, 32'h2130);
    repeat (3) @(posedge clock);
    chk(32'(move_halt), 32'h1);
    chk(32'(move_push), 32'h0);
    chk(32'(torque_limit_reached_flag), 32'h0);
    bus(1'b1, pps_pkg::ADDR_CTRL, 32'h0);
    // Next move sets the push bit at its own strobe, so push state starts afresh
    start_mv(32'h2020, 32'd700);
    wait_start(10, 1'b1);
    repeat (3) @(posedge clock);
    start_mv(32'h2060, BACK_OFF);
    wait_start(10, 1'b1);
    chk(last_dest, cmd_pos + BACK_OFF);
    chk(32'(move_push), 32'h1);
    repeat (3) @(posedge clock);
    chk(32'(torque_limit_reached_flag), 32'h1);
    stop_in <= 1'b1;
    repeat (5) @(posedge clock);
    chk(32'(move_push), 32'h0);
    chk(32'(torque_limit_reached_flag), 32'h0);
    stop_in <= 1'b0;
    press <= 1'b0;
    repeat (4) @(posedge clock);
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    report_and_stop();
  end
  initial begin
    failures = 0;
    compares = 0;
    start_cnt = 0;
    base = 0;
    rst = 1'b1;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    stop_in = 1'b0;
    press = 1'b0;
    run_len = 8'd4;
    fb_off = 32'h0;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    t_regs();
    t_abs_inc();
    t_wrap();
    t_update();
    t_push();
    report_and_stop();
  end
endmodule // tb
